/* hdl/fan_mf_pkg.sv */
/*
 fan_mf_pkg: constants shared by the fan and master/follower selection block.
 assumes a 25 MHz system clock and a classic Wishbone register bus.
*/
package fan_mf_pkg;
	// ************************************************
	// register offsets (byte addresses)
	// ************************************************
	localparam logic [7:0] ADR_ROLE = 8'h00;
	localparam logic [7:0] ADR_CTRL_SRC = 8'h04;
	localparam logic [7:0] ADR_SPD_SRC = 8'h08;
	localparam logic [7:0] ADR_TRQ_SRC = 8'h0c;
	localparam logic [7:0] ADR_SCHEME = 8'h10;
	localparam logic [7:0] ADR_TRQ_SEL = 8'h14;
	localparam logic [7:0] ADR_FAN_WAIT = 8'h18;
	localparam logic [7:0] ADR_START_WAIT = 8'h1c;
	localparam logic [7:0] ADR_WIN_POS = 8'h20;
	localparam logic [7:0] ADR_WIN_NEG = 8'h24;
	localparam logic [7:0] ADR_STATUS = 8'h28;
	// ************************************************
	// codes
	// ************************************************
	localparam logic [1:0] ROLE_ALONE = 2'h0;
	localparam logic [1:0] ROLE_MASTER = 2'h1;
	localparam logic [1:0] ROLE_FOLLOWER = 2'h2;
	localparam logic [1:0] CSRC_FIELDBUS = 2'h0;
	localparam logic [1:0] SPD_OWN = 2'h0;
	localparam logic [1:0] SPD_MASTER_REF = 2'h1;
	localparam logic [1:0] SPD_MASTER_RAMP = 2'h2;
	localparam logic [1:0] TRQ_NONE = 2'h0;
	localparam logic [1:0] TRQ_MASTER = 2'h1;
	localparam logic [1:0] TRQ_FIELDBUS = 2'h2;
	localparam logic [1:0] TRQ_ANALOG = 2'h3;
	localparam logic [1:0] SCHEME_CLOSED = 2'h3;
	localparam logic [2:0] TSEL_WINDOW = 3'h5;
	// ************************************************
	// reset values and timing
	// ************************************************
	localparam int CLK_HZ = 25000000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
	localparam logic [15:0] FAN_WAIT_RST = 16'h0000;
	localparam logic [15:0] START_WAIT_RST = 16'h0000;
	localparam logic [15:0] WIN_RST = 16'h0000;
endpackage

/* hdl/delay_count.sv */
/*
 delay_count: reloading down-counter of millisecond ticks.
 assumes tick is a one-cycle pulse on the same clock.
*/
`timescale 1ns/100ps
module delay_count
(
	// clock and reset
	input wire logic I_MCLK,
	input wire logic I_RSTN,
	// control
	input wire logic i_tick,
	input wire logic i_arm,
	input wire logic [15:0] i_load,
	// result
	output logic o_done
);
	typedef struct packed
	{
		logic [15:0] cnt;
		logic done;
	} st_t;
	st_t st_q;
	st_t st_d;
	always_comb
	begin
		st_d = st_q;
		if (!i_arm)
		begin
			st_d.cnt = i_load;
			st_d.done = 1'b0;
		end
		else if (st_q.cnt == 16'h0000)
			st_d.done = 1'b1;
		else if (i_tick)
			st_d.cnt = st_q.cnt - 16'h0001;
	end
	always_ff @(posedge I_MCLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			st_q <= '0;
		else
			st_q <= st_d;
	end
	assign o_done = st_q.done;
endmodule // delay_count

/* hdl/fan_mf_select.sv */
/*
 fan_mf_select: fan off-delay, drive role and follower source selection.
 assumes registers written over classic Wishbone, status inputs synchronous to I_MCLK.
*/
// Operation
// - fan output turns on immediately with a run request
// - fan turns off only after motor stops and off-delay elapses
// - role 0 stand-alone, 1 master, 2 follower
// - follower with control source 0 uses fieldbus command word
// - follower with control source 1..3 uses master internal command word
// - follower commanded by master starts once master runs and the start delay has elapsed
// - speed source 0: own reference from active control source
// - speed source 1: master first speed reference
// - speed source 2: master ramped reference, own ramp bypassed
// - follower waits start delay after master start; only in follower role
// - torque source 0 none, 1 master, 2 fieldbus, 3 analogue
// - open-loop schemes allow speed following only; torque needs code 3
// - window mode: torque control inside speed window, else speed control
`timescale 1ns/100ps
module fan_mf_select
(
	// clock and reset
	input wire logic I_MCLK,
	input wire logic I_RSTN,
	// wishbone slave
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	// drive status
	input wire logic i_run_request,
	input wire logic i_motor_stopped,
	input wire logic i_master_running,
	// command words
	input wire logic [15:0] i_fieldbus_cmd,
	input wire logic [15:0] i_master_cmd,
	input wire logic [15:0] i_local_cmd,
	// speed references
	input wire logic [15:0] i_own_speed_ref,
	input wire logic [15:0] i_master_speed_ref1,
	input wire logic [15:0] i_master_used_speed_ref,
	input wire logic [15:0] i_measured_speed,
	// torque references
	input wire logic [15:0] i_master_torque_ref,
	input wire logic [15:0] i_fieldbus_torque_ref,
	input wire logic [15:0] i_analog_torque_ref,
	// outputs
	output logic O_FAN_ON,
	output logic O_RUN_ENABLE,
	output logic O_IS_MASTER,
	output logic O_IS_FOLLOWER,
	output logic [15:0] O_CMD_WORD,
	output logic [15:0] O_SPEED_REF,
	output logic O_RAMP_BYPASS,
	output logic [15:0] O_TORQUE_REF,
	output logic O_TORQUE_MODE
);
	// ************************************************
	// state
	// ************************************************
	typedef enum logic [2:0]
	{
		FAN_OFF = 3'b001,
		FAN_RUN = 3'b010,
		FAN_COAST = 3'b100
	} fan_t;
	typedef struct packed
	{
		logic [1:0] role;
		logic [1:0] ctrl_src;
		logic [1:0] spd_src;
		logic [1:0] trq_src;
		logic [1:0] scheme;
		logic [2:0] trq_sel;
		logic [15:0] fan_wait;
		logic [15:0] start_wait;
		logic [15:0] win_pos;
		logic [15:0] win_neg;
		logic [15:0] tick_cnt;
		logic tick;
		fan_t fan;
		logic [31:0] rdat;
		logic ack;
		logic fan_on;
		logic run_en;
		logic is_master;
		logic is_follower;
		logic [15:0] cmd;
		logic [15:0] spd;
		logic bypass;
		logic [15:0] trq;
		logic trq_mode;
	} st_t;
	st_t st_q;
	st_t st_d;
	logic fan_done;
	logic start_done;
	logic follower;
	logic by_master;
	logic torque_ok;
	logic in_window;
	logic [16:0] hi_lim;
	logic [16:0] lo_lim;
	assign follower = (st_q.role == fan_mf_pkg::ROLE_FOLLOWER);
	assign by_master = follower && (st_q.ctrl_src != fan_mf_pkg::CSRC_FIELDBUS);
	assign torque_ok = (st_q.scheme == fan_mf_pkg::SCHEME_CLOSED);
	assign hi_lim = {1'b0, st_q.spd} + {1'b0, st_q.win_pos};
	assign lo_lim = {1'b0, st_q.spd} - {1'b0, st_q.win_neg};
	assign in_window = ({1'b0, i_measured_speed} <= hi_lim)
		&& (lo_lim[16] || ({1'b0, i_measured_speed} >= lo_lim));
	// ************************************************
	// delay counters
	// ************************************************
	delay_count fan_delay
	(
		.I_MCLK(I_MCLK),
		.I_RSTN(I_RSTN),
		.i_tick(st_q.tick),
		.i_arm(st_q.fan == FAN_COAST && i_motor_stopped),
		.i_load(st_q.fan_wait),
		.o_done(fan_done)
	);
	delay_count start_delay
	(
		.I_MCLK(I_MCLK),
		.I_RSTN(I_RSTN),
		.i_tick(st_q.tick),
		.i_arm(follower && i_master_running),
		.i_load(st_q.start_wait),
		.o_done(start_done)
	);
	// ************************************************
	// next state
	// ************************************************
	always_comb
	begin
		st_d = st_q;
		st_d.ack = 1'b0;
		// tick generator
		st_d.tick = 1'b0;
		if (st_q.tick_cnt == fan_mf_pkg::TICK_LAST)
		begin
			st_d.tick_cnt = 16'h0000;
			st_d.tick = 1'b1;
		end
		else
			st_d.tick_cnt = st_q.tick_cnt + 16'h0001;
		// register bus
		if (I_WB_CYC && I_WB_STB && !st_q.ack)
		begin
			st_d.ack = 1'b1;
			st_d.rdat = 32'h00000000;
			if (I_WB_WE && I_WB_SEL[0])
			begin
				case (I_WB_ADR)
					fan_mf_pkg::ADR_ROLE: st_d.role = I_WB_DAT[1:0];
					fan_mf_pkg::ADR_CTRL_SRC: st_d.ctrl_src = I_WB_DAT[1:0];
					fan_mf_pkg::ADR_SPD_SRC: st_d.spd_src = I_WB_DAT[1:0];
					fan_mf_pkg::ADR_TRQ_SRC: st_d.trq_src = I_WB_DAT[1:0];
					fan_mf_pkg::ADR_SCHEME: st_d.scheme = I_WB_DAT[1:0];
					fan_mf_pkg::ADR_TRQ_SEL: st_d.trq_sel = I_WB_DAT[2:0];
					default: st_d.rdat = 32'h00000000;
				endcase
			end
			if (I_WB_WE && (I_WB_SEL[1:0] == 2'h3))
			begin
				case (I_WB_ADR)
					fan_mf_pkg::ADR_FAN_WAIT: st_d.fan_wait = I_WB_DAT[15:0];
					fan_mf_pkg::ADR_START_WAIT: st_d.start_wait = I_WB_DAT[15:0];
					fan_mf_pkg::ADR_WIN_POS: st_d.win_pos = I_WB_DAT[15:0];
					fan_mf_pkg::ADR_WIN_NEG: st_d.win_neg = I_WB_DAT[15:0];
					default: st_d.rdat = 32'h00000000;
				endcase
			end
			if (!I_WB_WE)
			begin
				case (I_WB_ADR)
					fan_mf_pkg::ADR_ROLE: st_d.rdat = {30'h0, st_q.role};
					fan_mf_pkg::ADR_CTRL_SRC: st_d.rdat = {30'h0, st_q.ctrl_src};
					fan_mf_pkg::ADR_SPD_SRC: st_d.rdat = {30'h0, st_q.spd_src};
					fan_mf_pkg::ADR_TRQ_SRC: st_d.rdat = {30'h0, st_q.trq_src};
					fan_mf_pkg::ADR_SCHEME: st_d.rdat = {30'h0, st_q.scheme};
					fan_mf_pkg::ADR_TRQ_SEL: st_d.rdat = {29'h0, st_q.trq_sel};
					fan_mf_pkg::ADR_FAN_WAIT: st_d.rdat = {16'h0, st_q.fan_wait};
					fan_mf_pkg::ADR_START_WAIT: st_d.rdat = {16'h0, st_q.start_wait};
					fan_mf_pkg::ADR_WIN_POS: st_d.rdat = {16'h0, st_q.win_pos};
					fan_mf_pkg::ADR_WIN_NEG: st_d.rdat = {16'h0, st_q.win_neg};
					fan_mf_pkg::ADR_STATUS: st_d.rdat = {25'h0, st_q.trq_mode,
						st_q.bypass, st_q.run_en, st_q.is_follower,
						st_q.is_master, st_q.fan_on, in_window};
					default: st_d.rdat = 32'h00000000;
				endcase
			end
		end
		// fan sequencing
		case (st_q.fan)
			FAN_OFF:
			begin
				if (i_run_request)
					st_d.fan = FAN_RUN;
			end
			FAN_RUN:
			begin
				if (!i_run_request)
					st_d.fan = FAN_COAST;
			end
			FAN_COAST:
			begin
				if (i_run_request)
					st_d.fan = FAN_RUN;
				else if (fan_done && i_motor_stopped)
					st_d.fan = FAN_OFF;
			end
			default: st_d.fan = FAN_OFF;
		endcase
		st_d.fan_on = (st_d.fan != FAN_OFF);
		// role decode
		st_d.is_master = (st_q.role == fan_mf_pkg::ROLE_MASTER);
		st_d.is_follower = follower;
		// command source
		if (follower && !by_master)
		begin
			st_d.cmd = i_fieldbus_cmd;
			st_d.run_en = i_run_request && start_done;
		end
		else if (by_master)
		begin
			st_d.cmd = i_master_cmd;
			st_d.run_en = i_master_running && start_done;
		end
		else
		begin
			st_d.cmd = i_local_cmd;
			st_d.run_en = i_run_request;
		end
		// speed reference, master ignores speed source
		st_d.bypass = 1'b0;
		if (!follower)
			st_d.spd = i_own_speed_ref;
		else
		begin
			case (st_q.spd_src)
				fan_mf_pkg::SPD_OWN: st_d.spd = i_own_speed_ref;
				fan_mf_pkg::SPD_MASTER_REF: st_d.spd = i_master_speed_ref1;
				fan_mf_pkg::SPD_MASTER_RAMP:
				begin
					st_d.spd = i_master_used_speed_ref;
					st_d.bypass = 1'b1;
				end
				default: st_d.spd = i_own_speed_ref;
			endcase
		end
		// torque reference, closed loop only
		if (!torque_ok)
			st_d.trq = 16'h0000;
		else
		begin
			case (st_q.trq_src)
				fan_mf_pkg::TRQ_NONE: st_d.trq = 16'h0000;
				fan_mf_pkg::TRQ_MASTER: st_d.trq = i_master_torque_ref;
				fan_mf_pkg::TRQ_FIELDBUS: st_d.trq = i_fieldbus_torque_ref;
				fan_mf_pkg::TRQ_ANALOG: st_d.trq = i_analog_torque_ref;
				default: st_d.trq = 16'h0000;
			endcase
		end
		// torque mode per selection
		if (!torque_ok)
			st_d.trq_mode = 1'b0;
		else if (st_q.trq_sel == fan_mf_pkg::TSEL_WINDOW)
			st_d.trq_mode = in_window;
		else
			st_d.trq_mode = (st_q.trq_sel != 3'h0) && (st_q.trq_sel != 3'h1);
	end
	// ************************************************
	// registers
	// ************************************************
	always_ff @(posedge I_MCLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			st_q <= '0;
			st_q.fan <= FAN_OFF;
			st_q.fan_wait <= fan_mf_pkg::FAN_WAIT_RST;
			st_q.start_wait <= fan_mf_pkg::START_WAIT_RST;
			st_q.win_pos <= fan_mf_pkg::WIN_RST;
			st_q.win_neg <= fan_mf_pkg::WIN_RST;
		end
		else
			st_q <= st_d;
	end
	assign O_WB_DAT = st_q.rdat;
	assign O_WB_ACK = st_q.ack;
	assign O_FAN_ON = st_q.fan_on;
	assign O_RUN_ENABLE = st_q.run_en;
	assign O_IS_MASTER = st_q.is_master;
	assign O_IS_FOLLOWER = st_q.is_follower;
	assign O_CMD_WORD = st_q.cmd;
	assign O_SPEED_REF = st_q.spd;
	assign O_RAMP_BYPASS = st_q.bypass;
	assign O_TORQUE_REF = st_q.trq;
	assign O_TORQUE_MODE = st_q.trq_mode;
	// ************************************************
	// checks
	// ************************************************
	a_fan_on_run: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
		i_run_request |=> ##1 O_FAN_ON) else $error("fan not on after run request");
	a_fan_off_stopped: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
		$fell(O_FAN_ON) |-> $past(i_motor_stopped) && $past(fan_done))
		else $error("fan off while moving");
	a_master_role: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
		st_q.role == fan_mf_pkg::ROLE_MASTER |=> O_IS_MASTER || $changed(st_q.role))
		else $error("master role not shown");
	a_fieldbus_cmd: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
		follower && st_q.ctrl_src == 2'h0 && $stable(st_q.ctrl_src) && $stable(st_q.role)
		|=> O_CMD_WORD == $past(i_fieldbus_cmd)) else $error("fieldbus word not used");
	a_master_cmd: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
		by_master && $stable(st_q.ctrl_src) && $stable(st_q.role)
		|=> O_CMD_WORD == $past(i_master_cmd)) else $error("master word not used");
	a_follow_start: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
		O_RUN_ENABLE && $past(by_master) |-> $past(i_master_running))
		else $error("follower ran without master");
	a_ramp_bypass: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
		O_RAMP_BYPASS |-> O_SPEED_REF == $past(i_master_used_speed_ref))
		else $error("bypass with wrong reference");
	a_open_loop: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
		!torque_ok && $stable(st_q.scheme) |=> !O_TORQUE_MODE && O_TORQUE_REF == 16'h0000)
		else $error("torque in open loop");
	a_bus_ack: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
		I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK) else $error("no bus ack");
	a_own_speed: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
		follower && st_q.spd_src == fan_mf_pkg::SPD_OWN
		|=> O_SPEED_REF == $past(i_own_speed_ref) && !O_RAMP_BYPASS)
		else $error("own speed reference not used");
	a_master_ref: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
		follower && st_q.spd_src == fan_mf_pkg::SPD_MASTER_REF
		|=> O_SPEED_REF == $past(i_master_speed_ref1) && !O_RAMP_BYPASS)
		else $error("master first reference not used");
	a_alone_run: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
		st_q.role != fan_mf_pkg::ROLE_FOLLOWER |=> O_RUN_ENABLE == $past(i_run_request))
		else $error("start delay applied outside follower role");
	a_window_mode: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
		torque_ok && st_q.trq_sel == fan_mf_pkg::TSEL_WINDOW
		|=> O_TORQUE_MODE == $past(in_window)) else $error("window mode wrong");
endmodule // fan_mf_select

/* dv/master_drive_model.sv */
/*
 master_drive_model: far-side master drive on the system bus.
 assumes the follower block shares its clock and reset.
*/
`timescale 1ns/100ps
module master_drive_model
(
	// clock and reset
	input wire logic I_MCLK,
	input wire logic I_RSTN,
	// control
	input wire logic i_start,
	// system bus words
	output logic o_running,
	output logic [15:0] o_cmd,
	output logic [15:0] o_ref1,
	output logic [15:0] o_used_ref,
	output logic [15:0] o_trq_ref
);
	// master keeps its own speed source unset
	// torque selection fixed for this application
	always_ff @(posedge I_MCLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			o_running <= 1'b0;
		else
			o_running <= i_start;
	end
	assign o_cmd = 16'h00a5;
	assign o_ref1 = 16'h0500;
	assign o_used_ref = 16'h0600;
	assign o_trq_ref = 16'h0700;
endmodule // master_drive_model

/* dv/testbench.sv */
/*
 testbench: self-checking bench for fan_mf_select.
 assumes master_drive_model on the system bus side.
*/
`timescale 1ns/100ps
module testbench;
	logic I_MCLK = 1'b0;
	logic I_RSTN = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, run_req = 1'b0, stopped = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic m_start = 1'b0, m_run, fan, run_en, is_m, is_f, bypass, tmode;
	logic [15:0] fb_cmd = 16'h1111, loc_cmd = 16'h3333, own_ref = 16'h03e8, meas = 16'h03e8;
	logic [15:0] fb_trq = 16'h2222, an_trq = 16'h4444, m_cmd, m_ref1, m_used, m_trq;
	logic [15:0] cmd, spd, trq;
	int fail_count = 0;
	int cmp_count = 0;
	always #20 I_MCLK = ~I_MCLK;
	master_drive_model i_master (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .i_start(m_start),
		.o_running(m_run), .o_cmd(m_cmd), .o_ref1(m_ref1), .o_used_ref(m_used),
		.o_trq_ref(m_trq));
	fan_mf_select i_dut (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
		.O_WB_ACK(ack), .i_run_request(run_req), .i_motor_stopped(stopped),
		.i_master_running(m_run), .i_fieldbus_cmd(fb_cmd), .i_master_cmd(m_cmd),
		.i_local_cmd(loc_cmd), .i_own_speed_ref(own_ref), .i_master_speed_ref1(m_ref1),
		.i_master_used_speed_ref(m_used), .i_measured_speed(meas),
		.i_master_torque_ref(m_trq), .i_fieldbus_torque_ref(fb_trq),
		.i_analog_torque_ref(an_trq), .O_FAN_ON(fan), .O_RUN_ENABLE(run_en),
		.O_IS_MASTER(is_m), .O_IS_FOLLOWER(is_f), .O_CMD_WORD(cmd), .O_SPEED_REF(spd),
		.O_RAMP_BYPASS(bypass), .O_TORQUE_REF(trq), .O_TORQUE_MODE(tmode));
	// ************************************************
	// shared tasks
	// ************************************************
	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(posedge I_MCLK);
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do
		begin
			@(posedge I_MCLK);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 20)
		begin
			fail_count++;
			$display("wrong value at %0t: no bus answer", $time);
		end
		@(posedge I_MCLK);
	endtask
	// ************************************************
	// scenarios
	// ************************************************
	task automatic t_reset();
		wb(1'b0, fan_mf_pkg::ADR_STATUS, 32'h0);
		cmp(rd, 32'h1);
		wb(1'b1, 8'h40, 32'hffff);
		wb(1'b0, 8'h40, 32'h0);
		cmp(rd, 32'h0);
		cmp({fan, run_en, is_m, is_f, bypass, tmode}, 32'h0);
		cmp({cmd, trq}, {loc_cmd, 16'h0000});
	endtask
	task automatic t_role();
		for (int r = 0; r < 3; r++)
		begin
			wb(1'b1, fan_mf_pkg::ADR_ROLE, 32'(r));
			cyc_n(2);
			cmp({is_m, is_f}, (r == 1) ? 32'h2 : (r == 2) ? 32'h1 : 32'h0);
		end
	endtask
	task automatic t_cmd();
		for (int s = 0; s < 4; s++)
		begin
			wb(1'b1, fan_mf_pkg::ADR_CTRL_SRC, 32'(s));
			cyc_n(2);
			cmp(cmd, (s == 0) ? fb_cmd : m_cmd);
		end
	endtask
	task automatic t_speed();
		logic [16:0] exp[3];
		exp = '{{1'b0, own_ref}, {1'b0, m_ref1}, {1'b1, m_used}};
		for (int s = 0; s < 3; s++)
		begin
			wb(1'b1, fan_mf_pkg::ADR_SPD_SRC, 32'(s));
			cyc_n(2);
			cmp({bypass, spd}, exp[s]);
		end
		wb(1'b1, fan_mf_pkg::ADR_SPD_SRC, 32'h0);
		wb(1'b1, fan_mf_pkg::ADR_ROLE, 32'h1);
		cyc_n(2);
		cmp({bypass, spd}, {1'b0, own_ref});
	endtask
	task automatic t_torque();
		logic [15:0] exp[4];
		exp = '{16'h0, m_trq, fb_trq, an_trq};
		wb(1'b1, fan_mf_pkg::ADR_SCHEME, 32'h3);
		for (int s = 0; s < 4; s++)
		begin
			wb(1'b1, fan_mf_pkg::ADR_TRQ_SRC, 32'(s));
			cyc_n(2);
			cmp(trq, exp[s]);
		end
		wb(1'b1, fan_mf_pkg::ADR_TRQ_SRC, 32'h1);
		wb(1'b1, fan_mf_pkg::ADR_TRQ_SEL, 32'h2);
		cyc_n(2);
		cmp({tmode, trq}, {1'b1, m_trq});
		wb(1'b1, fan_mf_pkg::ADR_SCHEME, 32'h0);
		cyc_n(2);
		cmp({tmode, trq}, 32'h0);
	endtask
	task automatic t_window();
		logic [15:0] sp[4];
		sp = '{16'h03fc, 16'h044c, 16'h03c0, 16'h0384};
		wb(1'b1, fan_mf_pkg::ADR_ROLE, 32'h0);
		wb(1'b1, fan_mf_pkg::ADR_SCHEME, 32'h3);
		wb(1'b1, fan_mf_pkg::ADR_WIN_POS, 32'h32);
		wb(1'b1, fan_mf_pkg::ADR_WIN_NEG, 32'h32);
		wb(1'b1, fan_mf_pkg::ADR_TRQ_SEL, 32'h5);
		for (int i = 0; i < 4; i++)
		begin
			meas <= sp[i];
			cyc_n(3);
			cmp(tmode, (i % 2 == 0) ? 32'h1 : 32'h0);
		end
	endtask
	task automatic t_delays();
		int n;
		wb(1'b1, fan_mf_pkg::ADR_ROLE, 32'h2);
		wb(1'b1, fan_mf_pkg::ADR_CTRL_SRC, 32'h1);
		wb(1'b1, fan_mf_pkg::ADR_FAN_WAIT, 32'h2);
		wb(1'b1, fan_mf_pkg::ADR_START_WAIT, 32'h2);
		run_req <= 1'b1;
		cyc_n(3);
		cmp(fan, 32'h1);
		run_req <= 1'b0;
		stopped <= 1'b1;
		m_start <= 1'b1;
		cyc_n(20000);
		cmp({fan, run_en}, 32'h2);
		n = 0;
		while (n < 40000 && !(fan === 1'b0 && run_en === 1'b1))
		begin
			@(posedge I_MCLK);
			n++;
		end
		cmp({fan, run_en}, 32'h1);
		m_start <= 1'b0;
		cyc_n(4);
		cmp(run_en, 32'h0);
		wb(1'b1, fan_mf_pkg::ADR_ROLE, 32'h0);
		run_req <= 1'b1;
		cyc_n(3);
		cmp({fan, run_en}, 32'h3);
	endtask
	// ************************************************
	// main sequence and watchdog
	// ************************************************
	initial
	begin
		repeat (4) @(posedge I_MCLK);
		I_RSTN <= 1'b1;
		@(posedge I_MCLK);
		t_reset();
		t_role();
		t_cmd();
		t_speed();
		t_torque();
		t_window();
		t_delays();
		wrap_up();
	end
	initial
	begin
		#(40 * 90000);
		fail_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		wrap_up();
	end
endmodule // testbench
